//--- logic/ster_pkg.sv
// shared constants for the split-transaction error reporting block
package ster_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_STAT = 8'h00; // primary status, w1c
  localparam logic [7:0] OFS_SEC = 8'h04; // secondary status, w1c
  localparam logic [7:0] OFS_XSTAT = 8'h08; // extended status, w1c
  localparam logic [7:0] OFS_CTRL = 8'h0C; // control, read/write
  // widths
  localparam int STAT_W = 16; // conventional status register width
  localparam int XSTAT_W = 4; // extended status flags
  localparam int CTRL_W = 5; // control bits
  // conventional status bit positions
  localparam int ST_MDPE = 8; // master data parity error
  localparam int ST_STA = 11; // signaled target-abort
  localparam int ST_RTA = 12; // received target-abort
  localparam int ST_RMA = 13; // received master-abort
  localparam int ST_SSE = 14; // signaled system error
  localparam int ST_DPE = 15; // detected parity error
  // extended status bit positions
  localparam int XS_DISC = 0; // split completion discarded
  localparam int XS_UNEXP = 1; // unexpected split completion
  localparam int XS_SCEM = 2; // received split completion error message
  localparam int XS_NOTE = 3; // aborted request, driver notice
  // control bit positions
  localparam int CT_SERR_EN = 0; // system error pin enable
  localparam int CT_BRIDGE = 1; // device behaves as a bridge
  localparam int CT_NOTIFY = 2; // driver notice path usable
  localparam int CT_EARLY_TA = 3; // target-abort on late parity error
  localparam int CT_ANY_TAG = 4; // claim completions ignoring the tag
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [31:0] DAT_ZERO = 32'h00000000;
  // split completion message classes and indexes
  localparam logic [3:0] MSG_CLS1 = 4'h1;
  localparam logic [3:0] MSG_CLS2 = 4'h2;
  localparam logic [7:0] MSG_IDX_MA = 8'h00;
  localparam logic [7:0] MSG_IDX_TA = 8'h01;
  localparam logic [7:0] MSG_IDX_WPE = 8'h02;
  localparam logic [7:0] MSG_IDX_SWPE = 8'h01;
endpackage

//--- logic/ster_sticky.sv
// bank of sticky status flags, set by hardware, cleared by write-one
`timescale 1ns/10ps
module ster_sticky #(
  parameter int W = 16
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // set and clear strobes, one bit per flag
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // flag values
  output logic [W-1:0] q_o
);
  logic [W-1:0] q_q; // flag storage
  logic [W-1:0] q_d; // next flag values

  // per flag: a set in the clearing cycle wins, so no event is lost
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_comb begin
      q_d[b] = set_i[b] | (q_q[b] & ~clr_i[b]);
    end
  end

  // register the flags; clock enable freezes them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else if (ce_i) begin
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

//--- logic/ster_msg_dec.sv
// decodes a received split completion error message into status bits
`timescale 1ns/10ps
module ster_msg_dec (
  // message fields
  input wire logic [3:0] cls_i,
  input wire logic [7:0] idx_i,
  // status bits to set
  output logic rma_o,
  output logic rta_o,
  output logic mdpe_o
);
  import ster_pkg::*;

  // only the classes and indexes with a standard meaning map to bits;
  // byte count and device-specific messages set nothing here
  always_comb begin
    rma_o = 1'b0;
    rta_o = 1'b0;
    mdpe_o = 1'b0;
    if (cls_i == MSG_CLS1) begin
      rma_o = (idx_i == MSG_IDX_MA);
      rta_o = (idx_i == MSG_IDX_TA);
      mdpe_o = (idx_i == MSG_IDX_WPE);
    end else if (cls_i == MSG_CLS2) begin
      mdpe_o = (idx_i == MSG_IDX_SWPE);
    end
  end
endmodule

//--- logic/ster_top.sv
// error detection and status reporting for a split-transaction bus agent
`timescale 1ns/10ps
module ster_top (
  // clock, reset and clock enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // abort seen on a transaction this agent initiated
  input wire logic init_abort_i,
  input wire logic init_ta_i,
  input wire logic init_benign_i,
  input wire logic init_is_sc_i,
  input wire logic sc_risk_i,
  input wire logic sc_side_eff_i,
  // target side parity checks
  input wire logic addr_perr_i,
  input wire logic attr_perr_i,
  input wire logic devsel_early_i,
  input wire logic split_resp_i,
  output logic tgt_abort_o,
  output logic req_drop_o,
  // completer dword write and execution faults
  input wire logic dw_perr_i,
  input wire logic dw_split_i,
  input wire logic exec_fault_i,
  input wire logic [3:0] exec_cls_i,
  input wire logic [7:0] exec_idx_i,
  output logic scm_req_o,
  output logic [3:0] scm_cls_o,
  output logic [7:0] scm_idx_o,
  // incoming split completion
  input wire logic sc_start_i,
  input wire logic sc_tag_hit_i,
  input wire logic sc_inv_i,
  input wire logic sc_last_i,
  input wire logic sc_rx_perr_i,
  output logic sc_claim_o,
  output logic sc_discard_o,
  // incoming or forwarded split completion message
  input wire logic msg_rx_i,
  input wire logic msg_err_i,
  input wire logic [3:0] msg_cls_i,
  input wire logic [7:0] msg_idx_i,
  input wire logic msg_on_sec_i,
  input wire logic msg_fwd_i,
  // open-drain error pins, enable high while driving low
  output logic serr_n_o,
  output logic serr_oe_o,
  output logic perr_n_o,
  output logic perr_oe_o
);
  import ster_pkg::*;

  // completion absorb states, one-hot
  typedef enum logic [1:0] {
    SC_IDLE = 2'b01,
    SC_DROP = 2'b10
  } ster_sc_e;

  ster_sc_e sc_q, sc_d; // absorb state
  logic [CTRL_W-1:0] ctrl_q, ctrl_d; // control register
  logic ack_q, ack_d; // bus acknowledge
  logic [31:0] dat_q, dat_d; // read data
  logic serr_q, serr_d; // system error pin drive
  logic serr_n_q, serr_n_d; // low-true copy, so the pin leaves a flop
  logic perr_q, perr_d; // parity error pin drive
  logic perr_n_q, perr_n_d; // low-true copy, so the pin leaves a flop
  logic ta_q, ta_d; // target-abort request
  logic drop_q, drop_d; // request drop pulse
  logic claim_q, claim_d; // completion claim
  logic scm_q, scm_d; // message send request
  logic [3:0] cls_q, cls_d; // message class
  logic [7:0] idx_q, idx_d; // message index
  logic pend_q, pend_d; // execution fault waiting to be sent
  logic [3:0] pcls_q, pcls_d; // waiting class
  logic [7:0] pidx_q, pidx_d; // waiting index

  logic [STAT_W-1:0] stat_q, sec_q; // conventional status flags
  logic [XSTAT_W-1:0] xs_q; // extended flags
  logic [STAT_W-1:0] stat_set, sec_set, stat_clr, sec_clr;
  logic [XSTAT_W-1:0] xs_set, xs_clr;
  logic [31:0] wmask; // byte lanes of the write
  logic acc; // bus access taken this cycle
  logic wr; // write taken this cycle
  logic serr_en; // system error pin allowed
  logic bridge; // bridge behaviour selected
  logic m_rma, m_rta, m_mdpe; // decoded message bits
  logic sc_bad; // claimed completion must be discarded
  logic sc_claimed; // completion claimed this cycle
  logic ab_own; // abort on a non-completion request
  logic ab_sc; // abort on a completion we sent
  logic sc_disc; // aborted completion must be flagged
  logic serr_ev; // any cause for a system error
  logic unexp; // unexpected completion finished

  assign serr_en = ctrl_q[CT_SERR_EN];
  assign bridge = ctrl_q[CT_BRIDGE];
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // message decoder shared by the primary and secondary status paths
  ster_msg_dec u_dec (
    .cls_i(msg_cls_i),
    .idx_i(msg_idx_i),
    .rma_o(m_rma),
    .rta_o(m_rta),
    .mdpe_o(m_mdpe)
  );

  // event classification
  always_comb begin
    ab_own = init_abort_i & ~init_is_sc_i;
    ab_sc = init_abort_i & init_is_sc_i;
    // low risk, side-effect free completions are dropped quietly
    sc_disc = ab_sc & (sc_risk_i | sc_side_eff_i);
    // claim when the tag matches, or always if so configured
    sc_claimed = sc_start_i & (sc_tag_hit_i | ctrl_q[CT_ANY_TAG]);
    // unknown tag, or known tag with a bad address or count
    sc_bad = sc_claimed & (~sc_tag_hit_i | sc_inv_i);
    // benign master-aborts still raise nothing on the pin
    serr_ev = (ab_own & ~init_benign_i & ~ctrl_q[CT_NOTIFY])
            | addr_perr_i | attr_perr_i
            | sc_disc;
  end

  // absorb state: the whole completion is taken, then dropped
  always_comb begin
    sc_d = sc_q;
    unexp = 1'b0;
    unique case (sc_q)
      SC_IDLE: begin
        if (sc_bad) begin
          // a single data phase finishes at once
          if (sc_last_i) begin
            unexp = 1'b1;
          end else begin
            sc_d = SC_DROP;
          end
        end
      end
      SC_DROP: begin
        if (sc_last_i) begin
          unexp = 1'b1;
          sc_d = SC_IDLE;
        end
      end
      default: begin
        sc_d = SC_IDLE;
      end
    endcase
  end

  // status set vectors for both interfaces and the extended flags
  always_comb begin
    stat_set = '0;
    sec_set = '0;
    xs_set = '0;
    // own aborts update received bits; completions never do
    stat_set[ST_RMA] = ab_own & ~init_ta_i;
    stat_set[ST_RTA] = ab_own & init_ta_i;
    xs_set[XS_NOTE] = ab_own & ~init_benign_i & ctrl_q[CT_NOTIFY];
    // parity errors seen by this agent's checkers
    stat_set[ST_DPE] = addr_perr_i | attr_perr_i | dw_perr_i
                     | sc_rx_perr_i;
    stat_set[ST_MDPE] = sc_rx_perr_i;
    stat_set[ST_SSE] = serr_ev & serr_en;
    // a target-abort signalled on a late parity error
    stat_set[ST_STA] = ta_d;
    xs_set[XS_DISC] = sc_disc;
    xs_set[XS_UNEXP] = unexp;
    if (msg_rx_i) begin
      if (!bridge) begin
        xs_set[XS_SCEM] = msg_err_i;
        stat_set[ST_RMA] = stat_set[ST_RMA] | m_rma;
        stat_set[ST_RTA] = stat_set[ST_RTA] | m_rta;
        stat_set[ST_MDPE] = stat_set[ST_MDPE] | m_mdpe;
      end else if (msg_on_sec_i) begin
        // arrived on the secondary side
        sec_set[ST_RMA] = m_rma;
        sec_set[ST_RTA] = m_rta;
        sec_set[ST_MDPE] = m_mdpe;
        // forwarded upstream: signaled abort on the primary side
        stat_set[ST_STA] = stat_set[ST_STA] | (msg_fwd_i & m_rta);
      end else begin
        stat_set[ST_RMA] = stat_set[ST_RMA] | m_rma;
        stat_set[ST_RTA] = stat_set[ST_RTA] | m_rta;
        stat_set[ST_MDPE] = stat_set[ST_MDPE] | m_mdpe;
        sec_set[ST_STA] = msg_fwd_i & m_rta;
      end
    end
  end

  // write-one-to-clear strobes from the bus
  always_comb begin
    stat_clr = '0;
    sec_clr = '0;
    xs_clr = '0;
    ctrl_d = ctrl_q;
    if (wr) begin
      unique case (wb_adr_i)
        OFS_STAT: stat_clr = wb_dat_i[STAT_W-1:0] & wmask[STAT_W-1:0];
        OFS_SEC: sec_clr = wb_dat_i[STAT_W-1:0] & wmask[STAT_W-1:0];
        OFS_XSTAT: xs_clr = wb_dat_i[XSTAT_W-1:0] & wmask[XSTAT_W-1:0];
        OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_d = wb_dat_i[CTRL_W-1:0];
          end
        end
        default: begin
          // unmapped: write ignored, still acknowledged
        end
      endcase
    end
  end

  // flags stay until software clears them
  ster_sticky #(.W(STAT_W)) u_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(stat_set),
    .clr_i(stat_clr),
    .q_o(stat_q)
  );
  ster_sticky #(.W(STAT_W)) u_sec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(sec_set),
    .clr_i(sec_clr),
    .q_o(sec_q)
  );
  ster_sticky #(.W(XSTAT_W)) u_xs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(xs_set),
    .clr_i(xs_clr),
    .q_o(xs_q)
  );

  // bus answer: one wait state, unmapped reads return zero
  always_comb begin
    ack_d = acc;
    dat_d = DAT_ZERO;
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_STAT: dat_d[STAT_W-1:0] = stat_q;
        OFS_SEC: dat_d[STAT_W-1:0] = sec_q;
        OFS_XSTAT: dat_d[XSTAT_W-1:0] = xs_q;
        OFS_CTRL: dat_d[CTRL_W-1:0] = ctrl_q;
        default: dat_d = DAT_ZERO;
      endcase
    end
  end

  // pins and bus-facing pulses
  always_comb begin
    // the pin only moves while reporting is enabled
    serr_d = serr_ev & serr_en;
    serr_n_d = ~serr_d;
    // the check may come before or after the split response
    perr_d = dw_perr_i | sc_rx_perr_i;
    perr_n_d = ~perr_d;
    // late parity error after devsel: abort only if chosen
    ta_d = (addr_perr_i | attr_perr_i) & devsel_early_i
         & ctrl_q[CT_EARLY_TA];
    // a split attribute error cannot be routed back, so drop it
    drop_d = attr_perr_i & split_resp_i;
    claim_d = sc_claimed;
  end

  // message sender; a write parity error outranks a queued fault, which waits
  // while write parity errors hold the slot; a new fault arriving meanwhile overwrites it
  always_comb begin
    scm_d = 1'b0;
    cls_d = cls_q;
    idx_d = idx_q;
    pend_d = pend_q;
    pcls_d = pcls_q;
    pidx_d = pidx_q;
    if (exec_fault_i) begin
      pend_d = 1'b1;
      pcls_d = exec_cls_i;
      pidx_d = exec_idx_i;
    end
    if (dw_perr_i && dw_split_i) begin
      scm_d = 1'b1;
      cls_d = MSG_CLS2;
      idx_d = MSG_IDX_SWPE;
    end else if (pend_q) begin
      scm_d = 1'b1;
      cls_d = pcls_q;
      idx_d = pidx_q;
      pend_d = exec_fault_i;
    end else if (exec_fault_i) begin
      // nothing competes for the slot: send the fault at once
      scm_d = 1'b1;
      cls_d = exec_cls_i;
      idx_d = exec_idx_i;
      pend_d = 1'b0;
    end
  end

  // all state registers except the sticky flag banks; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_q <= SC_IDLE;
      ctrl_q <= CTRL_RST;
      ack_q <= 1'b0;
      dat_q <= DAT_ZERO;
      serr_q <= 1'b0;
      serr_n_q <= 1'b1;
      perr_q <= 1'b0;
      perr_n_q <= 1'b1;
      ta_q <= 1'b0;
      drop_q <= 1'b0;
      claim_q <= 1'b0;
      scm_q <= 1'b0;
      cls_q <= 4'h0;
      idx_q <= 8'h00;
      pend_q <= 1'b0;
      pcls_q <= 4'h0;
      pidx_q <= 8'h00;
    end else if (ce_i) begin
      sc_q <= sc_d;
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      serr_q <= serr_d;
      serr_n_q <= serr_n_d;
      perr_q <= perr_d;
      perr_n_q <= perr_n_d;
      ta_q <= ta_d;
      drop_q <= drop_d;
      claim_q <= claim_d;
      scm_q <= scm_d;
      cls_q <= cls_d;
      idx_q <= idx_d;
      pend_q <= pend_d;
      pcls_q <= pcls_d;
      pidx_q <= pidx_d;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign serr_n_o = serr_n_q;
  assign serr_oe_o = serr_q;
  assign perr_n_o = perr_n_q;
  assign perr_oe_o = perr_q;
  assign tgt_abort_o = ta_q;
  assign req_drop_o = drop_q;
  assign sc_claim_o = claim_q;
  // the one-hot bit of the drop state, no decode after the flop
  assign sc_discard_o = sc_q[1];
  assign scm_req_o = scm_q;
  assign scm_cls_o = cls_q;
  assign scm_idx_o = idx_q;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_serr_needs_en: assert property (
    !serr_n_o |-> $past(serr_en)
  ) else $error("system error pin driven while disabled");

  a_addr_perr_rep: assert property (
    ce_i && addr_perr_i && serr_en |=> !serr_n_o && stat_q[ST_DPE]
      && stat_q[ST_SSE]
  ) else $error("address parity error not reported");

  a_attr_split_drop: assert property (
    ce_i && attr_perr_i && split_resp_i |=> req_drop_o
  ) else $error("attribute error request not dropped");

  a_dw_perr_pin: assert property (
    ce_i && dw_perr_i |=> perr_oe_o && !perr_n_o
  ) else $error("write parity error without parity pin");

  a_dw_split_msg: assert property (
    ce_i && dw_perr_i && dw_split_i |=> scm_req_o
      && scm_cls_o == MSG_CLS2 && scm_idx_o == MSG_IDX_SWPE
  ) else $error("split write parity message missing");

  a_quiet_sc_drop: assert property (
    ce_i && ab_sc && !sc_risk_i && !sc_side_eff_i && !xs_q[XS_DISC]
      |=> !xs_q[XS_DISC]
  ) else $error("low risk completion flagged");

  a_side_eff_disc: assert property (
    ce_i && ab_sc && sc_side_eff_i |=> xs_q[XS_DISC]
  ) else $error("side effect completion not flagged");

  a_sc_no_rcv_ab: assert property (
    ce_i && ab_sc && !msg_rx_i |=> !$rose(stat_q[ST_RMA])
      && !$rose(stat_q[ST_RTA])
  ) else $error("aborted completion set received abort");

  a_rx_perr_bits: assert property (
    ce_i && sc_rx_perr_i |=> stat_q[ST_DPE] && stat_q[ST_MDPE]
      && !perr_n_o
  ) else $error("completion parity error not reported");

  a_unexp_flag: assert property (
    ce_i && sc_q == SC_DROP && sc_last_i |=> xs_q[XS_UNEXP]
      && !sc_discard_o
  ) else $error("unexpected completion not flagged");

  a_scem_flag: assert property (
    ce_i && msg_rx_i && msg_err_i && !bridge |=> xs_q[XS_SCEM]
  ) else $error("error message flag not set");

  a_wb_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");
endmodule

//--- testbench/ster_agent_model.sv
// far-side bus agents: one-cycle event strobes into the error block
`timescale 1ns/10ps
module ster_agent_model (
  // clock
  input wire logic clk_i,
  // event strobes and message fields
  output logic [21:0] ev_o,
  output logic [3:0] cls_o,
  output logic [7:0] idx_o
);
  // idle lines, fields scrambled so stale values never look valid
  initial begin
    ev_o = '0;
    cls_o = 4'hF;
    idx_o = 8'hFF;
  end
  // strobes last exactly one cycle; fields invert once released
  task automatic fire(input logic [21:0] v, input logic [3:0] c,
                      input logic [7:0] i);
    @(posedge clk_i);
    ev_o <= v;
    cls_o <= c;
    idx_o <= i;
    @(posedge clk_i);
    ev_o <= '0;
    cls_o <= ~c;
    idx_o <= ~i;
  endtask
endmodule

//--- testbench/test_split_txn_error_reporting.sv
// self-checking bench for the split-transaction error reporting block
`timescale 1ns/10ps
module test_split_txn_error_reporting;
  import ster_pkg::*;
  // strobe positions in the agent event vector
  localparam int AB = 0, TA = 1, BN = 2, ISC = 3, RSK = 4, SFX = 5;
  localparam int APE = 6, TPE = 7, DVE = 8, SPR = 9, DWP = 10, DWS = 11;
  localparam int EXF = 12, SST = 13, HIT = 14, INV = 15, LST = 16;
  localparam int RPE = 17, MRX = 18, MER = 19, SEC = 20, FWD = 21;
  // clock, reset and bus master state
  logic clk_i, rst_i, ce, cyc, stb, we, wb_ack_o;
  logic [7:0] adr, idx, scm_idx_o;
  logic [3:0] sel, cls, scm_cls_o;
  logic [31:0] wdat, wb_dat_o;
  logic [21:0] ev;
  logic tgt_abort_o, req_drop_o, scm_req_o, sc_claim_o, sc_discard_o;
  logic serr_n_o, serr_oe_o, perr_n_o, perr_oe_o;
  // bookkeeping and reference state
  int fails, num_checks, cycles;
  logic [4:0] ctrl;
  logic [31:0] lf;
  logic [21:0] evs[$];
  logic [11:0] msgs[$];

  ster_agent_model u_ster_agent_model (
    .clk_i(clk_i), .ev_o(ev), .cls_o(cls), .idx_o(idx)
  );
  // block under test; the enable drops once to prove the freeze
  ster_top u_ster_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .init_abort_i(ev[AB]), .init_ta_i(ev[TA]),
    .init_benign_i(ev[BN]), .init_is_sc_i(ev[ISC]), .sc_risk_i(ev[RSK]),
    .sc_side_eff_i(ev[SFX]), .addr_perr_i(ev[APE]), .attr_perr_i(ev[TPE]),
    .devsel_early_i(ev[DVE]), .split_resp_i(ev[SPR]),
    .tgt_abort_o(tgt_abort_o), .req_drop_o(req_drop_o),
    .dw_perr_i(ev[DWP]), .dw_split_i(ev[DWS]), .exec_fault_i(ev[EXF]),
    .exec_cls_i(cls), .exec_idx_i(idx), .scm_req_o(scm_req_o),
    .scm_cls_o(scm_cls_o), .scm_idx_o(scm_idx_o), .sc_start_i(ev[SST]),
    .sc_tag_hit_i(ev[HIT]), .sc_inv_i(ev[INV]), .sc_last_i(ev[LST]),
    .sc_rx_perr_i(ev[RPE]), .sc_claim_o(sc_claim_o),
    .sc_discard_o(sc_discard_o), .msg_rx_i(ev[MRX]), .msg_err_i(ev[MER]),
    .msg_cls_i(cls), .msg_idx_i(idx), .msg_on_sec_i(ev[SEC]),
    .msg_fwd_i(ev[FWD]), .serr_n_o(serr_n_o), .serr_oe_o(serr_oe_o),
    .perr_n_o(perr_n_o), .perr_oe_o(perr_oe_o)
  );

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, generous against roughly seven thousand expected cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [21:0] b(input int k);
    return 22'h1 << k;
  endfunction
  // pseudo-random source
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference model of one event cycle: outputs {serr,perr,ta,drop,scm,
  // claim} and the flags it leaves behind
  function automatic void predict(input logic [21:0] v, input logic [3:0] c,
    input logic [7:0] i, output logic [5:0] o, output logic [15:0] st,
    output logic [15:0] sc, output logic [3:0] xs);
    logic serr;
    logic [15:0] m;
    {serr, o, st, sc, xs, m} = '0;
    if (v[AB] && !v[ISC]) begin
      st[v[TA] ? ST_RTA : ST_RMA] = 1'b1;
      if (!v[BN] && ctrl[CT_NOTIFY]) xs[XS_NOTE] = 1'b1;
      else if (!v[BN]) serr = 1'b1;
    end
    // completion aborts never touch the received-abort bits
    if (v[AB] && v[ISC] && (v[RSK] || v[SFX])) begin
      xs[XS_DISC] = 1'b1;
      serr = 1'b1;
    end
    if (v[APE] || v[TPE]) {st[ST_DPE], serr} = 2'b11;
    if ((v[APE] || v[TPE]) && v[DVE] && ctrl[CT_EARLY_TA]) begin
      o[3] = 1'b1;
      st[ST_STA] = 1'b1;
    end
    if (v[TPE] && v[SPR]) o[2] = 1'b1;
    if (v[DWP]) {o[4], o[1], st[ST_DPE]} = {1'b1, v[DWS], 1'b1};
    if (v[EXF]) o[1] = 1'b1;
    if (v[RPE]) {o[4], st[ST_DPE], st[ST_MDPE]} = 3'b111;
    o[0] = v[SST] && (v[HIT] || ctrl[CT_ANY_TAG]);
    if (o[0] && (!v[HIT] || v[INV])) xs[XS_UNEXP] = 1'b1;
    if (v[MRX]) begin
      m[ST_RMA] = {c, i} == 12'h100;
      m[ST_RTA] = {c, i} == 12'h101;
      m[ST_MDPE] = {c, i} == 12'h102 || {c, i} == 12'h201;
      if (!ctrl[CT_BRIDGE]) xs[XS_SCEM] = v[MER];
      else if (v[FWD] && {c, i} == 12'h101) begin
        if (v[SEC]) st[ST_STA] = 1'b1;
        else sc[ST_STA] = 1'b1;
      end
    end
    if (ctrl[CT_BRIDGE] && v[SEC]) sc = sc | m;
    else st = st | m;
    if (serr && ctrl[CT_SERR_EN]) {o[5], st[ST_SSE]} = 2'b11;
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    // ack is due one cycle after the taking edge
    chk("ack", 32'h2, 32'(n));
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0, q);
    chk(n, e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask
  // compare the flag registers, then clear them all
  task automatic regs(input logic [15:0] st, input logic [15:0] sc,
                      input logic [3:0] xs);
    rd(OFS_STAT, {16'h0, st}, "status");
    rd(OFS_SEC, {16'h0, sc}, "secondary");
    rd(OFS_XSTAT, {28'h0, xs}, "xstatus");
    wr(OFS_STAT, 4'hF, 32'hFFFFFFFF);
    wr(OFS_SEC, 4'hF, 32'hFFFFFFFF);
    wr(OFS_XSTAT, 4'hF, 32'hFFFFFFFF);
  endtask
  task automatic setc(input logic [4:0] c);
    ctrl = c;
    wr(OFS_CTRL, 4'h1, {27'h0, c});
    rd(OFS_CTRL, {27'h0, c}, "ctrl");
  endtask
  // one event through the agent, pins checked in their single cycle
  task automatic t(input logic [21:0] v, input logic [3:0] c,
                   input logic [7:0] i);
    logic [5:0] o;
    logic [15:0] st, sc;
    logic [3:0] xs;
    predict(v, c, i, o, st, sc, xs);
    u_ster_agent_model.fire(v, c, i);
    #1;
    chk("pins", {24'h0, o[5], o[5], o[4], o[4], o[3:0]}, {24'h0, serr_oe_o,
      ~serr_n_o, perr_oe_o, ~perr_n_o, tgt_abort_o, req_drop_o, scm_req_o,
      sc_claim_o});
    if (o[1]) chk("scm", {20'h0, v[EXF] ? {c, i} : {MSG_CLS2, MSG_IDX_SWPE}},
      {20'h0, scm_cls_o, scm_idx_o});
    regs(st, sc, xs);
  endtask
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst_i, ce, cyc, stb, we, adr, sel, wdat} = {2'b11, 47'h0};
    {fails, num_checks, cycles} = '0;
    lf = 32'h17e0;
    evs = {b(AB), b(AB) | b(TA), b(AB) | b(BN), b(AB) | b(ISC),
      b(AB) | b(ISC) | b(RSK), b(AB) | b(ISC) | b(SFX) | b(TA), b(APE),
      b(APE) | b(DVE), b(TPE) | b(DVE), b(TPE) | b(SPR), b(DWP),
      b(DWP) | b(DWS), b(RPE), b(SST) | b(LST), b(SST) | b(LST) | b(HIT),
      b(SST) | b(LST) | b(HIT) | b(INV)};
    msgs = {12'h100, 12'h101, 12'h102, 12'h200, 12'h201, 12'h281};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    regs(16'h0, 16'h0, 4'h0);
    rd(OFS_CTRL, {27'h0, CTRL_RST}, "ctrl");
    wr(8'h10, 4'hF, 32'hFFFFFFFF);
    rd(8'h10, DAT_ZERO, "unmapped");
    for (int k = 0; k < 8; k++) begin
      lf = nxt(lf);
      setc(k < 5 ? 5'(32'h1F000D13 >> (8 * k)) | 5'(k == 4) : lf[4:0]);
      foreach (evs[j]) t(evs[j], 4'h0, 8'h00);
      foreach (msgs[j]) for (int f = 0; f < 4; f++)
        t(b(MRX) | b(MER) | (22'(f) << SEC), msgs[j][11:8],
          msgs[j][7:0]);
      t(b(EXF), lf[3:0], lf[11:4]);
      t(b(MRX) | b(MER), lf[15:12], lf[23:16]);
    end
    // multi-phase unexpected completion absorbed until its last phase
    setc(5'h10);
    u_ster_agent_model.fire(b(SST), 4'h0, 8'h00);
    #1;
    chk("absorb", 32'h3, {30'h0, sc_claim_o, sc_discard_o});
    u_ster_agent_model.fire(b(LST), 4'h0, 8'h00);
    #1;
    chk("absorb", 32'h0, {31'h0, sc_discard_o});
    regs(16'h0, 16'h0, 4'h2);
    // byte lanes gate clears and the control write
    u_ster_agent_model.fire(b(RPE), 4'h0, 8'h00);
    wr(OFS_STAT, 4'h1, 32'hFFFFFFFF);
    rd(OFS_STAT, 32'h8100, "status");
    wr(OFS_CTRL, 4'hE, 32'h1F);
    rd(OFS_CTRL, 32'h10, "ctrl");
    wr(OFS_STAT, 4'h2, 32'hFFFFFFFF);
    rd(OFS_STAT, DAT_ZERO, "status");
    // events while the enable is low leave no trace
    ce <= 1'b0;
    u_ster_agent_model.fire(b(APE) | b(RPE), 4'h0, 8'h00);
    ce <= 1'b1;
    #1;
    chk("frozen", 32'h0, {28'h0, perr_oe_o, serr_oe_o, tgt_abort_o,
      sc_claim_o});
    regs(16'h0, 16'h0, 4'h0);
    close_out();
  end
endmodule
